// ### nfc_active_field_sequencer.sv
// active peer field sequencer with its register port
//
// How it works
// - 212 uses carrier/64, 424 uses carrier/32
// - preset enables amplitude channel, disables phase
// - preset sets transport frame enable
// - transmitter enable only from field-on commands or auto response
// - field off after message, hold timer
// - peer mode enables detector, threshold select
// - auto response starts on peer field off
// - initial field-on, guard, then done event
// - no-response timer after field off
// - field on event, mask timer, then receive
// - field off event, response field-on, guard
// - target select enables field detector
// - target idle: only detector at peer threshold
// - rate detection or fixed rate target modes
// - start of receive, rate detected, display load
// - target auto response needs detected rate
// - go-to-normal copies rate, leaves detection mode
// - first target response uses count bits
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "nfc_active_defines.svh"
module nfc_active_field_sequencer #(
    parameter int TW = 16
) (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       fieldDetected,
    input  wire logic       txDone,
    input  wire logic       rxStart,
    input  wire logic       rateValid,
    input  wire logic [1:0] rateMeasured,
    output logic            txEnable,
    output logic            detectorEnable,
    output logic            caThreshold,
    output logic            rxWatch,
    output logic            bitTick
);
    if (TW < 9 || TW > 24) begin : g_bad_width
        $error("timer width out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  modeReg;
    logic [7:0]  opCtrl;
    logic [7:0]  auxReg;
    logic [1:0]  bitRate;
    logic [1:0]  detRate;
    logic [7:0]  events;
    logic [TW-1:0] gptLoad;
    logic [TW-1:0] nrtLoad;
    logic [TW-1:0] mrtLoad;
    logic        rateOk;
    logic        firstResp;
    logic        fieldPrev;

    nfc_active_pkg::seq_state_t state;
    nfc_active_pkg::seq_state_t next_state;
    logic [TW-1:0] timer;
    logic [TW-1:0] next_timer;
    logic [2:0]  slots;
    logic [2:0]  next_slots;
    logic        initialCmd;
    logic        next_initialCmd;

    wire targetMode = modeReg[`MODE_TARGET];
    wire autoResp   = modeReg[`MODE_AUTORESP];
    wire rateDetect = modeReg[`MODE_RATEDET];
    wire opIdle     = (opCtrl == 8'h00);
    wire fieldOn    = fieldDetected && !fieldPrev;
    wire fieldOff   = !fieldDetected && fieldPrev;
    wire timerZero  = (timer == '0);

    wire wrMode  = wr && (addr == `ADDR_MODE);
    wire wrOp    = wr && (addr == `ADDR_OPCTRL);
    wire wrAux   = wr && (addr == `ADDR_AUX);
    wire wrRate  = wr && (addr == `ADDR_BITRATE);
    wire wrGpt   = wr && (addr == `ADDR_GPT);
    wire wrNrt   = wr && (addr == `ADDR_NRT);
    wire wrMrt   = wr && (addr == `ADDR_MRT);
    wire wrEvt   = wr && (addr == `ADDR_EVENTS);
    wire wrCmd   = wr && (addr == `ADDR_COMMAND);
    wire cmdInit = wrCmd && (wdata == `CMD_INIT_ON);
    wire cmdResp = wrCmd && (wdata == `CMD_RESP_ON);
    wire cmdPre  = wrCmd && (wdata == `CMD_PRESET);
    wire cmdNorm = wrCmd && (wdata == `CMD_GO_NORMAL);
    wire cmdMrt  = wrCmd && (wdata == `CMD_START_MRT);
    wire idleLike = (state == nfc_active_pkg::ST_IDLE) ||
                    (state == nfc_active_pkg::ST_TGTLOW);
    // auto response in target mode only once the rate is known
    wire autoOk = autoResp && (!targetMode || rateOk);
    // response slot count from count bits
    wire [2:0] respSlots = {1'b0, auxReg[`AUX_N1], auxReg[`AUX_N0]};

    ////////////////////////////////////////////////////////////////////
    // register writes and auto effects
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            modeReg <= 8'h00;
            opCtrl  <= 8'h00;
            auxReg  <= 8'h00;
            bitRate <= `RATE_106;
            gptLoad <= '0;
            nrtLoad <= '0;
            mrtLoad <= '0;
        end else begin
            if (wrMode) modeReg <= wdata;
            else if (cmdNorm) begin
                bitRate <= detRate;
                modeReg[`MODE_RATEDET] <= 1'b0;
            end
            if (wrOp) opCtrl <= wdata;
            if (wrAux) auxReg <= {wdata[7:4] & 4'h7, wdata[3] & 1'b0,
                                   wdata[2:0]};
            else if (cmdPre) begin
                auxReg[`AUX_AMEN] <= 1'b1;
                auxReg[`AUX_PMEN] <= 1'b0;
                auxReg[`AUX_TRANSPORT] <= 1'b1;
            end
            if (wrRate && !cmdNorm) bitRate <= wdata[1:0];
            if (wrGpt) gptLoad <= {{(TW-8){1'b0}}, wdata} << (TW - 8);
            if (wrNrt) nrtLoad <= {{(TW-8){1'b0}}, wdata} << (TW - 8);
            if (wrMrt) mrtLoad <= {{(TW-8){1'b0}}, wdata};
        end
    end

    // detector enabled in peer mode or target mode
    wire peerMode = modeReg[`MODE_AUTORESP] || targetMode
                    || !idleLike;
    assign detectorEnable = auxReg[`AUX_FDEN] || peerMode;
    // collision threshold only during collision avoidance of a field-on command or auto response
    assign caThreshold = (state == nfc_active_pkg::ST_CA);

    ////////////////////////////////////////////////////////////////////
    // rate detection and events
    logic [7:0] evSet;
    always_comb begin
        evSet = 8'h00;
        if (fieldOn) evSet[`EV_EON] = 1'b1;
        if (fieldOff) evSet[`EV_EOF] = 1'b1;
        if (state == nfc_active_pkg::ST_GUARD && timerZero)
            evSet[`EV_CAT] = 1'b1;
        if (state == nfc_active_pkg::ST_CA && fieldDetected)
            evSet[`EV_CAC] = 1'b1;
        if (state == nfc_active_pkg::ST_WAITON && timerZero && !fieldOn)
            evSet[`EV_NRT] = 1'b1;
        if (state == nfc_active_pkg::ST_HOLD && timerZero)
            evSet[`EV_GPT] = 1'b1;
        if (state == nfc_active_pkg::ST_RECV && rxStart && rateDetect)
            evSet[`EV_SOR] = 1'b1;
        if (state == nfc_active_pkg::ST_RECV && rateValid && rateDetect)
            evSet[`EV_RATE] = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            events    <= 8'h00;
            detRate   <= `RATE_106;
            rateOk    <= 1'b0;
            fieldPrev <= 1'b0;
            firstResp <= 1'b0;
        end else begin
            fieldPrev <= fieldDetected;
            events <= (wrEvt ? events & ~wdata : events) | evSet;
            if (evSet[`EV_RATE]) begin
                detRate   <= rateMeasured;
                rateOk    <= 1'b1;
                firstResp <= 1'b1;
            end else if (targetMode && opIdle && idleLike) begin
                rateOk <= 1'b0;
            end
            if (state == nfc_active_pkg::ST_GUARD) firstResp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // field sequencer
    always_comb begin
        next_state = state;
        next_timer = timerZero ? timer : timer - TW'(1);
        next_slots = slots;
        next_initialCmd = initialCmd;
        case (state)
            nfc_active_pkg::ST_IDLE,
            nfc_active_pkg::ST_TGTLOW: begin
                if (targetMode && opIdle)
                    next_state = nfc_active_pkg::ST_TGTLOW;
                else
                    next_state = nfc_active_pkg::ST_IDLE;
                if (cmdInit) begin
                    next_state = nfc_active_pkg::ST_CA;
                    next_timer = TW'(`CA_SLOT_CYC);
                    next_slots = 3'h0;
                    next_initialCmd = 1'b1;
                end else if (cmdResp) begin
                    next_state = nfc_active_pkg::ST_CA;
                    next_timer = TW'(`CA_SLOT_CYC);
                    next_slots = respSlots;
                    next_initialCmd = 1'b0;
                end else if (cmdMrt) begin
                    next_state = nfc_active_pkg::ST_MASK;
                    next_timer = mrtLoad;
                end
            end
            nfc_active_pkg::ST_CA: begin
                if (fieldDetected)
                    next_state = nfc_active_pkg::ST_IDLE;
                else if (timerZero && slots != 3'h0) begin
                    next_slots = slots - 3'h1;
                    next_timer = TW'(`CA_SLOT_CYC);
                end else if (timerZero) begin
                    next_state = nfc_active_pkg::ST_GUARD;
                    next_timer = initialCmd ? TW'(`GUARD_INIT_CYC)
                                            : TW'(`GUARD_ACT_CYC);
                end
            end
            nfc_active_pkg::ST_GUARD: begin
                if (timerZero) next_state = nfc_active_pkg::ST_FIELD;
            end
            nfc_active_pkg::ST_FIELD: begin
                if (txDone) begin
                    next_state = nfc_active_pkg::ST_HOLD;
                    next_timer = gptLoad;
                end
            end
            nfc_active_pkg::ST_HOLD: begin
                if (timerZero) begin
                    next_state = nfc_active_pkg::ST_WAITON;
                    next_timer = nrtLoad;
                end
            end
            nfc_active_pkg::ST_WAITON: begin
                if (fieldOn) begin
                    next_state = nfc_active_pkg::ST_MASK;
                    next_timer = mrtLoad;
                end else if (timerZero)
                    next_state = nfc_active_pkg::ST_IDLE;
            end
            nfc_active_pkg::ST_MASK: begin
                if (timerZero) next_state = nfc_active_pkg::ST_RECV;
            end
            nfc_active_pkg::ST_RECV: begin
                if (fieldOff && autoOk) begin
                    next_state = nfc_active_pkg::ST_CA;
                    next_timer = TW'(`CA_SLOT_CYC);
                    // first target reply takes count bits
                    next_slots = firstResp ? respSlots
                                           : 3'h0;
                    next_initialCmd = 1'b0;
                end else if (fieldOff)
                    next_state = nfc_active_pkg::ST_IDLE;
            end
            default: next_state = nfc_active_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= nfc_active_pkg::ST_IDLE;
            timer      <= '0;
            slots      <= 3'h0;
            initialCmd <= 1'b0;
        end else begin
            state      <= next_state;
            timer      <= next_timer;
            slots      <= next_slots;
            initialCmd <= next_initialCmd;
        end
    end

    // transmitter only through the field-on sequence
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) txEnable <= 1'b0;
        else txEnable <= (next_state == nfc_active_pkg::ST_GUARD) ||
                         (next_state == nfc_active_pkg::ST_FIELD) ||
                         (next_state == nfc_active_pkg::ST_HOLD);
    end
    assign rxWatch = (state == nfc_active_pkg::ST_RECV);

    ////////////////////////////////////////////////////////////////////
    // bit-rate enable
    wire [1:0] rateSel = (targetMode && rateDetect) ? detRate : bitRate;
    wire [7:0] divisor = (rateSel == `RATE_424) ? `DIV_424 :
                         (rateSel == `RATE_212) ? `DIV_212 :
                         `DIV_106;
    rate_divider #(.WIDTH(8)) u_div (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .run     (!idleLike),
        .divisor (divisor),
        .tick    (bitTick)
    );

    ////////////////////////////////////////////////////////////////////
    // read port
    wire [7:0] stat = {4'h0, state};
    wire [7:0] rdMux =
        (addr == `ADDR_MODE)    ? modeReg :
        (addr == `ADDR_OPCTRL)  ? opCtrl :
        (addr == `ADDR_AUX)     ? {auxReg[7:3], detectorEnable,
                                   auxReg[1:0]} :
        (addr == `ADDR_BITRATE) ? {6'h00, bitRate} :
        (addr == `ADDR_GPT)     ? gptLoad[TW-1 -: 8] :
        (addr == `ADDR_NRT)     ? nrtLoad[TW-1 -: 8] :
        (addr == `ADDR_MRT)     ? mrtLoad[7:0] :
        (addr == `ADDR_EVENTS)  ? events :
        (addr == `ADDR_STATUS)  ? stat :
        (addr == `ADDR_DETRATE) ? {rateOk, 5'h00, detRate} :
        8'h00;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) rdata <= 8'h00;
        else if (rd) rdata <= rdMux;
        else rdata <= 8'h00;
    end
endmodule : nfc_active_field_sequencer
`default_nettype wire

// ### nfc_active_defines.svh
// constants for the active peer field sequencer
`ifndef NFC_ACTIVE_DEFINES_SVH
`define NFC_ACTIVE_DEFINES_SVH
`define ADDR_MODE       4'h0
`define ADDR_OPCTRL     4'h1
`define ADDR_AUX        4'h2
`define ADDR_BITRATE    4'h3
`define ADDR_TIMERS     4'h4
`define ADDR_GPT        4'h5
`define ADDR_NRT        4'h6
`define ADDR_MRT        4'h7
`define ADDR_EVENTS     4'h8
`define ADDR_STATUS     4'h9
`define ADDR_DETRATE    4'hA
`define ADDR_COMMAND    4'hB
`define MODE_TARGET     0
`define MODE_AUTORESP   1
`define MODE_RATEDET    2
`define AUX_N0          0
`define AUX_N1          1
`define AUX_FDEN        2
`define AUX_TXEN        3
`define AUX_TRANSPORT   4
`define AUX_AMEN        5
`define AUX_PMEN        6
`define CMD_INIT_ON     8'h01
`define CMD_RESP_ON     8'h02
`define CMD_PRESET      8'h03
`define CMD_GO_NORMAL   8'h04
`define CMD_START_MRT   8'h05
`define CMD_TRANSMIT    8'h06
`define EV_CAT          0
`define EV_CAC          1
`define EV_EON          2
`define EV_EOF          3
`define EV_NRT          4
`define EV_GPT          5
`define EV_SOR          6
`define EV_RATE         7
`define RATE_106        2'h0
`define RATE_212        2'h1
`define RATE_424        2'h2
`define DIV_212         8'h40
`define DIV_424         8'h20
`define DIV_106         8'h80
`define GUARD_INIT_NS   5000
`define GUARD_ACT_NS    1000
`define CLK_NS          10
`define CA_SLOT_NS      1000
`define GUARD_INIT_CYC  ((`GUARD_INIT_NS + `CLK_NS - 1) / `CLK_NS)
`define GUARD_ACT_CYC   ((`GUARD_ACT_NS + `CLK_NS - 1) / `CLK_NS)
`define CA_SLOT_CYC     ((`CA_SLOT_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### nfc_active_pkg.sv
// types for the active peer field sequencer
package nfc_active_pkg;
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_CA      = 4'b0001,
        ST_GUARD   = 4'b0010,
        ST_FIELD   = 4'b0011,
        ST_HOLD    = 4'b0100,
        ST_WAITON  = 4'b0101,
        ST_MASK    = 4'b0110,
        ST_RECV    = 4'b0111,
        ST_TGTLOW  = 4'b1000
    } seq_state_t;
endpackage : nfc_active_pkg

// ### rate_divider.sv
// divider making a one-cycle bit-rate enable from the carrier clock
`timescale 1ns/10ps
`default_nettype none
module rate_divider #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  tick
);
    logic [WIDTH-1:0] count;
    wire              wrap = (count >= divisor - WIDTH'(1));

    if (WIDTH < 6) begin : g_bad_width
        $error("rate_divider: width too small");
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= (!run || wrap) ? '0 : count + WIDTH'(1);
            tick  <= run && wrap;
        end
    end
endmodule : rate_divider
`default_nettype wire

// ### nfc_active_field_sequencer_chk.sv
// port checker for the active peer field sequencer
`timescale 1ns/10ps
`default_nettype none
module nfc_active_field_sequencer_chk (
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic [3:0] addr,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       fieldDetected,
    input wire logic       txDone,
    input wire logic       txEnable,
    input wire logic       detectorEnable,
    input wire logic       caThreshold,
    input wire logic       rxWatch,
    input wire logic       bitTick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    // helper state
    logic       sawDone;
    logic [8:0] caLen;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sawDone <= 1'b0;
            caLen   <= 9'h000;
        end else begin
            sawDone <= txDone | (sawDone & txEnable);
            caLen   <= caThreshold ? caLen + 9'h001 : 9'h000;
        end
    end
    sequence s_field_up;
        !txEnable ##1 txEnable;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_read_idle_zero:
        assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
    a_ca_detector:
        assert property (caThreshold |-> detectorEnable)
        else $error("collision threshold without detector");
    a_field_from_ca:
        assert property (s_field_up |-> $past(caThreshold) ||
                         $past(caThreshold, 2))
        else $error("field on without collision avoidance");
    a_ca_slot_len:
        assert property (s_field_up |-> caLen inside {9'h065, 9'h0CA,
                                                      9'h12F, 9'h194})
        else $error("collision slot length wrong");
    a_off_after_msg:
        assert property ($fell(txEnable) |-> sawDone)
        else $error("field off without message end");
    a_rx_needs_field:
        assert property ($rose(rxWatch) |-> fieldDetected)
        else $error("receive watch without peer field");
    a_rx_quiet:
        assert property (rxWatch |-> !txEnable && !caThreshold)
        else $error("receive watch with own field");
    a_ca_cause:
        assert property ($rose(caThreshold) |-> !fieldDetected ||
                         ($past(wr) && $past(addr) == 4'hB))
        else $error("collision avoidance without cause");
    a_tick_single:
        assert property (bitTick |=> !bitTick)
        else $error("bit tick longer than one cycle");
endmodule : nfc_active_field_sequencer_chk
`default_nettype wire

// ### nfc_peer_model.sv
// remote peer: raises its field some cycles after ours drops
`timescale 1ns/10ps
`default_nettype none
module nfc_peer_model (
    input  wire logic       ref_clk,
    input  wire logic       txEnable,
    input  wire logic       answer,
    input  wire logic       jam,
    input  wire logic [9:0] delay,
    output logic            fieldDetected
);
    logic peerOn;
    initial begin
        peerOn = 1'b0;
        forever begin
            @(negedge txEnable);
            if (answer === 1'b1) begin
                repeat (delay) @(posedge ref_clk);
                peerOn <= 1'b1;
                repeat (300) @(posedge ref_clk);
                peerOn <= 1'b0;
            end
        end
    end
    assign fieldDetected = peerOn | jam;
endmodule : nfc_peer_model
`default_nettype wire

// ### nfc_active_field_sequencer_bench.sv
// testbench for the active peer field sequencer
`timescale 1ns/10ps
`default_nettype none
`include "nfc_active_defines.svh"
module nfc_active_field_sequencer_bench;
    logic       ref_clk, arst_n, wr, rd, txDone, rxStart, rateValid;
    logic       fieldDetected, txEnable, detectorEnable, caThreshold;
    logic       rxWatch, bitTick, answer, jam;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, v;
    logic [1:0] rateMeasured;
    logic [9:0] delay;
    int         miscompares, totalChecks, n;
    nfc_active_field_sequencer dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .fieldDetected(fieldDetected),
        .txDone(txDone), .rxStart(rxStart), .rateValid(rateValid),
        .rateMeasured(rateMeasured), .txEnable(txEnable),
        .detectorEnable(detectorEnable), .caThreshold(caThreshold),
        .rxWatch(rxWatch), .bitTick(bitTick));
    nfc_peer_model peer (
        .ref_clk(ref_clk), .txEnable(txEnable), .answer(answer), .jam(jam),
        .delay(delay), .fieldDetected(fieldDetected));
    ////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic pulse(input int s);
        @(posedge ref_clk);
        txDone    <= (s == 0);
        rxStart   <= (s == 1);
        rateValid <= (s == 2);
        @(posedge ref_clk);
        {txDone, rxStart, rateValid} <= 3'b000;
        #1;
    endtask : pulse
    task automatic wait_sig(input int s, input logic lv, input int lim,
                            output int k);
        logic cur;
        k = 0;
        cur = (s == 0) ? txEnable : (s == 1) ? rxWatch : caThreshold;
        while (cur !== lv && k < lim) begin
            @(posedge ref_clk);
            #1;
            k++;
            cur = (s == 0) ? txEnable : (s == 1) ? rxWatch : caThreshold;
        end
        chk("wait", cur, lv);
    endtask : wait_sig
    task automatic tick_gap(output int g);
        g = 0;
        while (bitTick !== 1'b1 && g < 300) begin
            @(posedge ref_clk);
            #1 g++;
        end
        g = 0;
        do begin
            @(posedge ref_clk);
            #1 g++;
        end while (bitTick !== 1'b1 && g < 300);
    endtask : tick_gap
    task automatic testDone;
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : testDone
    ////////////////////////////////////////////////////////////////////////
    // clock, watchdog
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #300000;
        miscompares++;
        testDone();
    end
    ////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        {addr, wdata, wr, rd, txDone, rxStart, rateValid} = '0;
        {arst_n, answer, jam, rateMeasured} = '0;
        {miscompares, totalChecks} = '0;
        delay = 10'h014;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd_reg(`ADDR_STATUS, v);
        chk("state", v, 8'(nfc_active_pkg::ST_IDLE));
        rd_reg(4'hC, v);
        chk("unmapped", v, 8'h00);
        wr_reg(`ADDR_AUX, 8'h08);
        rd_reg(`ADDR_AUX, v);
        chk("tx bit", {v[3], txEnable}, 8'h00);
        wr_reg(`ADDR_COMMAND, `CMD_PRESET);
        rd_reg(`ADDR_AUX, v);
        chk("preset", v & 8'h70, 8'h30);
        $display("test map done");
        wr_reg(`ADDR_MODE, 8'h02);
        wr_reg(`ADDR_AUX, 8'h00);
        wr_reg(`ADDR_BITRATE, 8'h01);
        wr_reg(`ADDR_GPT, 8'h01);
        wr_reg(`ADDR_NRT, 8'h01);
        wr_reg(`ADDR_MRT, 8'h10);
        answer <= 1'b1;
        wr_reg(`ADDR_COMMAND, `CMD_INIT_ON);
        chk("ca", {caThreshold, detectorEnable}, 8'h03);
        wait_sig(0, 1'b1, 300, n);
        repeat (520) @(posedge ref_clk);
        rd_reg(`ADDR_EVENTS, v);
        chk("done ev", v[0], 8'h01);
        tick_gap(n);
        chk("gap 212", 8'(n), 8'h40);
        wr_reg(`ADDR_EVENTS, 8'hFF);
        pulse(0);
        wait_sig(0, 1'b0, 400, n);
        chk("hold", (n >= 250 && n <= 260), 8'h01);
        wait_sig(1, 1'b1, 200, n);
        rd_reg(`ADDR_EVENTS, v);
        chk("on ev", {v[4], v[2]}, 8'h01);
        wait_sig(2, 1'b1, 400, n);
        rd_reg(`ADDR_EVENTS, v);
        chk("off ev", v[3], 8'h01);
        wait_sig(0, 1'b1, 300, n);
        wr_reg(`ADDR_EVENTS, 8'hFF);
        repeat (120) @(posedge ref_clk);
        rd_reg(`ADDR_EVENTS, v);
        chk("resp done", v[0], 8'h01);
        $display("test initiator loop done");
        wr_reg(`ADDR_MODE, 8'h00);
        answer <= 1'b0;
        pulse(0);
        wait_sig(0, 1'b0, 400, n);
        repeat (270) @(posedge ref_clk);
        rd_reg(`ADDR_EVENTS, v);
        chk("no resp", {v[4], v[2]}, 8'h02);
        wr_reg(`ADDR_EVENTS, 8'hFF);
        jam <= 1'b1;
        wr_reg(`ADDR_COMMAND, `CMD_INIT_ON);
        repeat (150) @(posedge ref_clk);
        rd_reg(`ADDR_EVENTS, v);
        chk("collision", {v[1], txEnable}, 8'h02);
        jam <= 1'b0;
        $display("test timeout and collision done");
        wr_reg(`ADDR_EVENTS, 8'hFF);
        wr_reg(`ADDR_OPCTRL, 8'h00);
        wr_reg(`ADDR_MODE, 8'h07);
        chk("tgt low", {detectorEnable, caThreshold, rxWatch}, 8'h04);
        rd_reg(`ADDR_STATUS, v);
        chk("tgt state", v, 8'(nfc_active_pkg::ST_TGTLOW));
        jam <= 1'b1;
        rateMeasured <= `RATE_424;
        wr_reg(`ADDR_COMMAND, `CMD_START_MRT);
        repeat (30) @(posedge ref_clk);
        #1 chk("tgt watch", rxWatch, 8'h01);
        pulse(1);
        pulse(2);
        rd_reg(`ADDR_EVENTS, v);
        chk("tgt ev", {v[7], v[6], v[2]}, 8'h07);
        rd_reg(`ADDR_DETRATE, v);
        chk("det rate", v, 8'h82);
        wr_reg(`ADDR_COMMAND, `CMD_GO_NORMAL);
        rd_reg(`ADDR_BITRATE, v);
        chk("copied rate", v, 8'h02);
        rd_reg(`ADDR_MODE, v);
        chk("normal", v[2], 8'h00);
        wr_reg(`ADDR_AUX, 8'h01);
        jam <= 1'b0;
        wait_sig(2, 1'b1, 50, n);
        wait_sig(2, 1'b0, 400, n);
        chk("n slots", n > 150, 8'h01);
        wait_sig(0, 1'b1, 300, n);
        tick_gap(n);
        chk("gap 424", 8'(n), 8'h20);
        repeat (110) @(posedge ref_clk);
        rd_reg(`ADDR_EVENTS, v);
        chk("tgt done", v[0], 8'h01);
        pulse(0);
        wait_sig(0, 1'b0, 400, n);
        $display("test target done");
        testDone();
    end
endmodule : nfc_active_field_sequencer_bench
bind nfc_active_field_sequencer nfc_active_field_sequencer_chk u_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wr(wr), .rd(rd),
    .rdata(rdata), .fieldDetected(fieldDetected), .txDone(txDone),
    .txEnable(txEnable), .detectorEnable(detectorEnable),
    .caThreshold(caThreshold), .rxWatch(rxWatch), .bitTick(bitTick));
`default_nettype wire
